// File: rtl/bru_pkg.sv
// shared constants and types for the byte rotate unit
package bru_pkg;
  localparam int BRU_DATA_W = 8;
  localparam int BRU_MSB = 7;
  localparam int BRU_LSB = 0;
  localparam logic [7:0] BRU_BYTE_RST = 8'h00;
  localparam logic BRU_CARRY_RST = 1'b0;
  localparam int BRU_OP_LATENCY = 1;

  // rotate operations issued by the decoder
  typedef enum logic [2:0] {
    BRU_OP_NONE,
    BRU_OP_ROTATE_LEFT_MEM,
    BRU_OP_ROTATE_LEFT_TO_ACC,
    BRU_OP_ROTATE_LEFT_THRU_CARRY_MEM,
    BRU_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC,
    BRU_OP_ROTATE_RIGHT_MEM,
    BRU_OP_ROTATE_RIGHT_TO_ACC,
    BRU_OP_ROTATE_RIGHT_THRU_CARRY_MEM
  } bru_op_t;
endpackage : bru_pkg

// File: rtl/bru_shifter.sv
// combinational one-bit rotator, plain or through carry
`timescale 1ns/1ps
module bru_shifter
  import bru_pkg::*;
(
  input wire logic [7:0] operand,
  input wire logic carry_in,
  input wire logic dir_right,
  input wire logic thru_carry,
  output logic [7:0] result,
  output logic carry_out
);
  logic fill_lsb;
  logic fill_msb;

  always_comb begin
    // plain rotates recycle the falling-out bit, carry rotates take old carry
    fill_lsb = thru_carry ? carry_in : operand[BRU_MSB];
    fill_msb = thru_carry ? carry_in : operand[BRU_LSB];
    if (dir_right) begin
      result = {fill_msb, operand[7:1]};
      carry_out = operand[BRU_LSB];
    end else begin
      result = {operand[6:0], fill_lsb};
      carry_out = operand[BRU_MSB];
    end
  end
endmodule : bru_shifter

// File: rtl/bru_unit.sv
// byte rotate unit: registered rotate of a memory byte into memory or accumulator
`timescale 1ns/1ps
// What this block does
// (RULE1) Rotate-left-through-carry on memory moves carry into bit 0, old bit 7 into carry, writes memory.
// (RULE2) The accumulator form of that rotate puts the result in the accumulator and leaves memory alone.
// (RULE3) Plain rotate-right on memory moves bit 0 into bit 7, writes memory and touches no flag.
// (RULE4) The accumulator form of rotate-right puts the result in the accumulator, memory and flags kept.
// (RULE5) Rotate-right-through-carry on memory moves carry into bit 7, old bit 0 into carry, writes memory.
// (RULE6) Accumulator rotate-left moves bit 7 into bit 0, loads the accumulator, keeps memory and flags.
// (RULE7) Through-carry rotates change only carry and leave every other status flag as it was.
module bru_unit
  import bru_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire bru_op_t op_code,
  input wire logic [7:0] mem_operand,
  input wire logic carry_flag,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic [7:0] working_accumulator,
  output logic acc_we,
  output logic [7:0] carry_wdata,
  output logic carry_we,
  output logic done
);
  typedef struct packed {
    logic [7:0] mem_wdata;
    logic mem_we;
    logic [7:0] acc;
    logic acc_we;
    logic carry;
    logic carry_we;
    logic done;
  } bru_state_t;

  bru_state_t state;
  bru_state_t next_state;
  logic dir_right;
  logic thru_carry;
  logic to_acc;
  logic [7:0] rot_result;
  logic rot_carry;

  always_comb begin
    dir_right = 1'b0;
    thru_carry = 1'b0;
    to_acc = 1'b0;
    unique case (op_code)
      BRU_OP_NONE: begin
        // refused: decodes to nothing and op_live stays low
      end
      BRU_OP_ROTATE_LEFT_MEM: begin
        // plain rotate left to memory: memory strobe only, no flag
      end
      BRU_OP_ROTATE_LEFT_TO_ACC: begin
        to_acc = 1'b1; // see (RULE6)
      end
      BRU_OP_ROTATE_LEFT_THRU_CARRY_MEM: begin
        thru_carry = 1'b1; // see (RULE1)
      end
      BRU_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC: begin
        thru_carry = 1'b1; // see (RULE2)
        to_acc = 1'b1;
      end
      BRU_OP_ROTATE_RIGHT_MEM: begin
        dir_right = 1'b1; // see (RULE3)
      end
      BRU_OP_ROTATE_RIGHT_TO_ACC: begin
        dir_right = 1'b1; // see (RULE4)
        to_acc = 1'b1;
      end
      BRU_OP_ROTATE_RIGHT_THRU_CARRY_MEM: begin
        dir_right = 1'b1; // see (RULE5)
        thru_carry = 1'b1;
      end
    endcase
  end

  bru_shifter bru_shifter_inst (
    .operand(mem_operand),
    .carry_in(carry_flag),
    .dir_right(dir_right),
    .thru_carry(thru_carry),
    .result(rot_result),
    .carry_out(rot_carry)
  );

  // no carry forwarding: back-to-back carry ops need the caller's updated flag
  logic op_live;
  assign op_live = op_valid && (op_code != BRU_OP_NONE);

  always_comb begin
    next_state = state;
    next_state.mem_we = 1'b0;
    next_state.acc_we = 1'b0;
    next_state.carry_we = 1'b0;
    next_state.done = op_live;
    if (op_live) begin
      // accumulator forms never strobe memory, so the byte stays intact
      next_state.mem_we = !to_acc; // see (RULE2) see (RULE4) see (RULE6)
      next_state.acc_we = to_acc;
      if (to_acc) begin
        next_state.acc = rot_result;
      end else begin
        next_state.mem_wdata = rot_result;
      end
      // only carry is ever written; other flags have no write path here
      next_state.carry_we = thru_carry; // see (RULE7)
      if (thru_carry) begin
        next_state.carry = rot_carry; // see (RULE1) see (RULE5)
      end
    end
  end

  // sync reset; every output sits low while it is held
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= '{BRU_BYTE_RST, 1'b0, BRU_BYTE_RST, 1'b0, BRU_CARRY_RST, 1'b0, 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign mem_wdata = state.mem_wdata;
  assign mem_we = state.mem_we;
  assign working_accumulator = state.acc;
  assign acc_we = state.acc_we;
  // carry travels in bit 0 of a byte-wide flag write bus, upper bits zero
  assign carry_wdata = {7'h00, state.carry};
  assign carry_we = state.carry_we;
  assign done = state.done;

  // answer checks: every live op shows up one edge after it is taken
  a_lrc_mem_result: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RULE1)
    op_valid && op_code == BRU_OP_ROTATE_LEFT_THRU_CARRY_MEM |=>
      mem_we && mem_wdata == {$past(mem_operand[6:0]), $past(carry_flag)}
      && carry_we && carry_wdata[0] == $past(mem_operand[7]))
    else $error("left thru carry memory result wrong");

  a_lrc_acc_result: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RULE2)
    op_valid && op_code == BRU_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC |=>
      acc_we && !mem_we && working_accumulator == {$past(mem_operand[6:0]), $past(carry_flag)}
      && carry_we && carry_wdata[0] == $past(mem_operand[7]))
    else $error("left thru carry accumulator result wrong");

  a_rr_mem_result: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RULE3)
    op_valid && op_code == BRU_OP_ROTATE_RIGHT_MEM |=>
      mem_we && !carry_we && mem_wdata == {$past(mem_operand[0]), $past(mem_operand[7:1])})
    else $error("rotate right memory result wrong");

  a_rr_acc_result: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RULE4)
    op_valid && op_code == BRU_OP_ROTATE_RIGHT_TO_ACC |=>
      acc_we && !mem_we && !carry_we
      && working_accumulator == {$past(mem_operand[0]), $past(mem_operand[7:1])})
    else $error("rotate right accumulator result wrong");

  a_rrc_mem_result: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RULE5)
    op_valid && op_code == BRU_OP_ROTATE_RIGHT_THRU_CARRY_MEM |=>
      mem_we && mem_wdata == {$past(carry_flag), $past(mem_operand[7:1])}
      && carry_we && carry_wdata[0] == $past(mem_operand[0]))
    else $error("right thru carry memory result wrong");

  a_rl_acc_result: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RULE6)
    op_valid && op_code == BRU_OP_ROTATE_LEFT_TO_ACC |=>
      acc_we && !mem_we && !carry_we
      && working_accumulator == {$past(mem_operand[6:0]), $past(mem_operand[7])})
    else $error("rotate left accumulator result wrong");

  a_rl_mem_result: assert property (@(posedge sys_clk) disable iff (!rst_b)
    op_valid && op_code == BRU_OP_ROTATE_LEFT_MEM |=>
      mem_we && !acc_we && !carry_we
      && mem_wdata == {$past(mem_operand[6:0]), $past(mem_operand[7])})
    else $error("rotate left memory result wrong");

  a_flags_only_carry: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RULE7)
    carry_we |-> carry_wdata[7:1] == 7'h00 && $past(op_valid)
      && ($past(op_code) == BRU_OP_ROTATE_LEFT_THRU_CARRY_MEM
      || $past(op_code) == BRU_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC
      || $past(op_code) == BRU_OP_ROTATE_RIGHT_THRU_CARRY_MEM))
    else $error("flag write outside carry rotate");

  a_carry_we_thru: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RULE7)
    op_valid && (op_code == BRU_OP_ROTATE_LEFT_THRU_CARRY_MEM
      || op_code == BRU_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC
      || op_code == BRU_OP_ROTATE_RIGHT_THRU_CARRY_MEM) |=> carry_we && done)
    else $error("carry rotate without carry write");

  // refused requests must leave every strobe low
  a_refused_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!op_valid || op_code == BRU_OP_NONE) |=>
      !done && !mem_we && !acc_we && !carry_we)
    else $error("strobe after refused request");

  a_done_from_op: assert property (@(posedge sys_clk) disable iff (!rst_b)
    done |-> $past(op_valid) && $past(op_code) != BRU_OP_NONE)
    else $error("done without a live request");

  // hold checks; the edge after a reset is skipped since reset clears all at once
  a_mem_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RULE2) (RULE6)
    $past(rst_b) && !mem_we |-> $stable(mem_wdata))
    else $error("memory write data moved without a write");

  a_acc_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $past(rst_b) && !acc_we |-> $stable(working_accumulator))
    else $error("accumulator moved without a load");

  a_carry_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RULE3) (RULE4)
    $past(rst_b) && !carry_we |-> $stable(carry_wdata))
    else $error("carry data moved without a carry write");

  // upper bits of the flag bus never carry another flag
  a_carry_upper_zero: assert property (@(posedge sys_clk) disable iff (!rst_b) // see (RULE7)
    carry_wdata[7:1] == 7'h00)
    else $error("flag bus upper bits set");

  a_reset_clears: assert property (@(posedge sys_clk)
    !rst_b |=> !done && !mem_we && !acc_we && !carry_we
      && mem_wdata == BRU_BYTE_RST && working_accumulator == BRU_BYTE_RST
      && carry_wdata[0] == BRU_CARRY_RST)
    else $error("outputs not cleared by reset");

  a_strobe_exclusive: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(mem_we && acc_we) && ((mem_we || acc_we) == done))
    else $error("write strobes inconsistent");
endmodule : bru_unit

// File: verification/tb_bru_unit.sv
// self-checking bench for the byte rotate unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_bru_unit
  import bru_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic op_valid = 1'b0;
  bru_op_t op_code = BRU_OP_NONE;
  logic [7:0] mem_operand = 8'h00;
  logic carry_flag = 1'b0;
  logic [7:0] mem_wdata, working_accumulator, carry_wdata;
  logic mem_we, acc_we, carry_we, done;
  logic [7:0] exp_mem = 8'h00;
  logic [7:0] exp_acc = 8'h00;
  logic [7:0] exp_cw = 8'h00;
  int n_fail = 0;
  int tests_run = 0;
  bru_unit bru_unit_inst (.sys_clk(sys_clk), .rst_b(rst_b), .op_valid(op_valid),
    .op_code(op_code), .mem_operand(mem_operand), .carry_flag(carry_flag),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .working_accumulator(working_accumulator),
    .acc_we(acc_we), .carry_wdata(carry_wdata), .carry_we(carry_we), .done(done));
  always #5 sys_clk = ~sys_clk;
  // {new carry, rotated byte}; carry passes through for the plain forms
  function automatic logic [8:0] rot(bru_op_t op, logic [7:0] d, logic c);
    case (op)
      BRU_OP_ROTATE_LEFT_MEM, BRU_OP_ROTATE_LEFT_TO_ACC: return {c, d[6:0], d[7]};
      BRU_OP_ROTATE_LEFT_THRU_CARRY_MEM, BRU_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC:
        return {d[7], d[6:0], c};
      BRU_OP_ROTATE_RIGHT_MEM, BRU_OP_ROTATE_RIGHT_TO_ACC: return {c, d[0], d[7:1]};
      BRU_OP_ROTATE_RIGHT_THRU_CARRY_MEM: return {d[0], c, d[7:1]};
      default: return {c, d};
    endcase
  endfunction : rot
  task automatic check_idle();
    `CHK("mem_we", 1'b0, mem_we)
    `CHK("acc_we", 1'b0, acc_we)
    `CHK("carry_we", 1'b0, carry_we)
    `CHK("done", 1'b0, done)
  endtask : check_idle
  // drive one op just after an edge, check its answer one cycle later
  task automatic run_op(bru_op_t op, logic v, logic [7:0] d, logic c);
    logic [8:0] r;
    logic tk, to_acc, thru;
    op_valid = v;
    op_code = op;
    mem_operand = d;
    carry_flag = c;
    @(posedge sys_clk);
    #1;
    r = rot(op, d, c);
    tk = v && (op != BRU_OP_NONE);
    to_acc = op inside {BRU_OP_ROTATE_LEFT_TO_ACC, BRU_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC,
      BRU_OP_ROTATE_RIGHT_TO_ACC};
    thru = op inside {BRU_OP_ROTATE_LEFT_THRU_CARRY_MEM,
      BRU_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC, BRU_OP_ROTATE_RIGHT_THRU_CARRY_MEM};
    if (tk && !to_acc) exp_mem = r[7:0];
    if (tk && to_acc) exp_acc = r[7:0];
    if (tk && thru) exp_cw = {7'h00, r[8]};
    `CHK("done", tk, done)
    `CHK("mem_we", tk && !to_acc, mem_we)
    `CHK("mem_wdata", exp_mem, mem_wdata)
    `CHK("acc_we", tk && to_acc, acc_we)
    `CHK("working_accumulator", exp_acc, working_accumulator)
    `CHK("carry_we", tk && thru, carry_we)
    `CHK("carry_wdata", exp_cw, carry_wdata)
  endtask : run_op
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    // generous: under a thousand cycles expected
    #100us;
    n_fail++;
    summarize();
  end
  initial begin
    void'($urandom(32'h8B5075AD));
    repeat (5) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    check_idle();
    // corner operands for six codes (not rotate-left-to-memory), then each code once, then refusals
    run_op(BRU_OP_ROTATE_RIGHT_THRU_CARRY_MEM, 1'b1, 8'h01, 1'b1);
    run_op(BRU_OP_ROTATE_LEFT_TO_ACC, 1'b1, 8'h81, 1'b0);
    run_op(BRU_OP_ROTATE_LEFT_THRU_CARRY_MEM, 1'b1, 8'h80, 1'b0);
    run_op(BRU_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC, 1'b1, 8'h7F, 1'b1);
    run_op(BRU_OP_ROTATE_RIGHT_MEM, 1'b1, 8'h01, 1'b0);
    run_op(BRU_OP_ROTATE_RIGHT_TO_ACC, 1'b1, 8'hFE, 1'b1);
    for (int i = 0; i < 8; i++) run_op(bru_op_t'(i), 1'b1, 8'hA5, i[0]);
    for (int i = 0; i < 8; i++) run_op(bru_op_t'(i), 1'b0, 8'h3C, 1'b1);
    for (int i = 0; i < 400; i++) begin
      if (i == 200) begin
        // mid-run reset clears every output
        rst_b = 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK("mem_wdata", 8'h00, mem_wdata)
        `CHK("working_accumulator", 8'h00, working_accumulator)
        check_idle();
        rst_b = 1'b1;
        {exp_mem, exp_acc, exp_cw} = '0;
      end
      run_op(bru_op_t'($urandom_range(0, 7)), $urandom_range(0, 3) != 0,
        8'($urandom), 1'($urandom));
    end
    op_valid = 1'b0;
    @(posedge sys_clk);
    #1;
    check_idle();
    summarize();
  end
endmodule : tb_bru_unit
